// [port_e_pin_control.sv]
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module port_e_pin_control (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic [1:0]               regAddr,
  input  wire logic [7:0]               regWdata,
  input  wire logic                     regWr,
  input  wire logic                     regRd,
  output logic      [7:0]               regRdata,
  input  wire logic                     masterClearEnableCfg,
  input  wire logic                     unit3PinSelectCfg,
  input  wire port_e_pkg::periph_out_s  periphOut,
  output port_e_pkg::periph_in_s        periphIn,
  input  wire logic [2:0]               pinIoIn,
  output logic      [2:0]               pinIoOut,
  output logic      [2:0]               pinIoOe_n,
  input  wire logic                     pin3Input,
  output logic                          masterClear_n,
  output logic                          pin3PullupEnable
);

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  logic [2:0] latch_q;
  logic [2:0] direction_q;
  logic [2:0] analogSel_q;
  logic       pullup_q;
  logic [7:0] rdata_q;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] sync3_q;
  logic [3:0] pinLevel_q;
  logic [2:0] drive;
  logic [2:0] driveVal;
  logic [7:0] rdata_d;

  // --------------------------------------------------------------------------
  // software registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      latch_q <= port_e_pkg::LATCH_RESET;
    end else if (regWr && (regAddr == port_e_pkg::ADDR_PIN_LEVELS ||
                           regAddr == port_e_pkg::ADDR_LATCH)) begin
      latch_q <= regWdata[2:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      direction_q <= port_e_pkg::DIRECTION_RESET;
      pullup_q    <= port_e_pkg::PULLUP_RESET;
    end else if (regWr && regAddr == port_e_pkg::ADDR_DIRECTION) begin
      direction_q <= regWdata[2:0];
      pullup_q    <= regWdata[port_e_pkg::PULLUP_POS];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      analogSel_q <= port_e_pkg::ANALOG_RESET;
    end else if (regWr && regAddr == port_e_pkg::ADDR_ANALOG_SEL) begin
      analogSel_q <= regWdata[2:0];
    end
  end

  // --------------------------------------------------------------------------
  // pin input synchroniser
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_q    <= 4'h0;
      sync2_q    <= 4'h0;
      sync3_q    <= 4'h0;
      pinLevel_q <= 4'h0;
    end else begin
      sync1_q <= {pin3Input, pinIoIn};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      for (int i = 0; i < 4; i++) begin
        if (sync2_q[i] == sync3_q[i]) begin
          pinLevel_q[i] <= sync3_q[i];
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // output priority per pin
  // --------------------------------------------------------------------------
  always_comb begin
    drive    = ~direction_q;
    driveVal = latch_q;
    // pin 0: pwm a, then compare 3, then latch; peripherals only while unit3PinSelectCfg is low
    if (!unit3PinSelectCfg && periphOut.pwmAEn) begin
      driveVal[0] = periphOut.pwmA;
    end else if (!unit3PinSelectCfg && periphOut.cmp3En) begin
      driveVal[0] = periphOut.cmp3;
    end
    if (periphOut.pwmBEn) begin
      driveVal[1] = periphOut.pwmB;
    end
    if (periphOut.cmp5En) begin
      driveVal[2] = periphOut.cmp5;
    end
  end

  // analog select not used here: outputs drive in analog mode too
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinIoOut  <= 3'h0;
      pinIoOe_n <= 3'h7;
    end else begin
      pinIoOut  <= driveVal;
      pinIoOe_n <= ~drive;
    end
  end

  // --------------------------------------------------------------------------
  // inputs to peripherals and reset
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      periphIn <= '0;
    end else begin
      periphIn.capture3 <= direction_q[0] && !unit3PinSelectCfg && !analogSel_q[0]
                           && pinLevel_q[0];
      periphIn.capture5 <= direction_q[2] && !analogSel_q[2] && pinLevel_q[2];
      periphIn.analogEn <= analogSel_q;
    end
  end

  // raw pin passes straight through: reset must work without clock
  assign masterClear_n    = masterClearEnableCfg ? pin3Input : 1'b1;
  assign pin3PullupEnable = masterClearEnableCfg | pullup_q;

  // --------------------------------------------------------------------------
  // read path
  // --------------------------------------------------------------------------
  always_comb begin
    rdata_d = 8'h00;
    if (regAddr == port_e_pkg::ADDR_PIN_LEVELS) begin
      rdata_d[2:0] = pinLevel_q[2:0] & ~analogSel_q & direction_q;
      rdata_d[port_e_pkg::PIN3_POS] = pinLevel_q[3] & ~masterClearEnableCfg;
    end else if (regAddr == port_e_pkg::ADDR_LATCH) begin
      rdata_d[2:0] = latch_q;
    end else if (regAddr == port_e_pkg::ADDR_DIRECTION) begin
      rdata_d[2:0] = direction_q;
      rdata_d[port_e_pkg::PULLUP_POS] = pullup_q;
    end else begin
      rdata_d[2:0] = analogSel_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (regRd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign regRdata = rdata_q;

endmodule // port_e_pin_control

`default_nettype wire

// [port_e_pkg.sv]
package port_e_pkg;

  // --------------------------------------------------------------------------
  // register indices on the plain port
  // --------------------------------------------------------------------------
  localparam logic [1:0] ADDR_PIN_LEVELS  = 2'h0;
  localparam logic [1:0] ADDR_LATCH       = 2'h1;
  localparam logic [1:0] ADDR_DIRECTION   = 2'h2;
  localparam logic [1:0] ADDR_ANALOG_SEL  = 2'h3;

  // --------------------------------------------------------------------------
  // field positions and reset values
  // --------------------------------------------------------------------------
  localparam int         IO_PINS          = 3;
  localparam int         PIN3_POS         = 3;
  localparam int         PULLUP_POS       = 7;
  localparam logic [2:0] ANALOG_RESET     = 3'h7;
  localparam logic [2:0] DIRECTION_RESET  = 3'h7;
  localparam logic       PULLUP_RESET     = 1'h1;
  localparam logic [2:0] LATCH_RESET      = 3'h0;
  localparam int         SYNC_STAGES      = 3;

  // --------------------------------------------------------------------------
  // peripheral output requests toward the pins
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic pwmAEn;
    logic pwmA;
    logic pwmBEn;
    logic pwmB;
    logic cmp3En;
    logic cmp3;
    logic cmp5En;
    logic cmp5;
  } periph_out_s;

  // capture and analog inputs delivered to peripherals
  typedef struct packed {
    logic       capture3;
    logic       capture5;
    logic [2:0] analogEn;
  } periph_in_s;

endpackage

// [port_e_pin_control_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module port_e_pin_control_monitor (
  input wire logic                    clk,
  input wire logic                    rst,
  input wire logic [1:0]              regAddr,
  input wire logic [7:0]              regWdata,
  input wire logic                    regWr,
  input wire logic                    regRd,
  input wire logic [7:0]              regRdata,
  input wire logic                    masterClearEnableCfg,
  input wire logic                    unit3PinSelectCfg,
  input wire port_e_pkg::periph_out_s periphOut,
  input wire logic [2:0]              pinIoOut,
  input wire logic [2:0]              pinIoOe_n,
  input wire logic                    pin3Input,
  input wire logic                    masterClear_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence dirWrite;
    regWr && regAddr == port_e_pkg::ADDR_DIRECTION;
  endsequence
  chk_rdata_quiet: assert property (!regRd |=> regRdata == 8'h00)
    else $error("read data not idle");
  chk_unused_zero: assert property (regRd |=> regRdata[6:4] == 3'h0)
    else $error("unused bits set");
  chk_clear_pass: assert property (masterClearEnableCfg |-> masterClear_n == pin3Input)
    else $error("clear not passed");
  chk_clear_off: assert property (!masterClearEnableCfg |-> masterClear_n)
    else $error("clear active");
  chk_reset_dir: assert property ($past(rst) |-> pinIoOe_n == 3'h7)
    else $error("drivers on after reset");
  chk_dir_drive: assert property (dirWrite ##1 !(regWr && regAddr == port_e_pkg::ADDR_DIRECTION)
    |=> pinIoOe_n == $past(regWdata[2:0], 2))
    else $error("enable not from direction");
  chk_pwmb_wins: assert property ($past(periphOut.pwmBEn) && !$past(rst) && !pinIoOe_n[1]
    |-> pinIoOut[1] == $past(periphOut.pwmB)) else $error("pin1 not pwm b");
  chk_cmp5_wins: assert property ($past(periphOut.cmp5En) && !$past(rst) && !pinIoOe_n[2]
    |-> pinIoOut[2] == $past(periphOut.cmp5)) else $error("pin2 not cmp5");
  chk_pwma_first: assert property ($past(periphOut.pwmAEn) && !$past(unit3PinSelectCfg)
    && !$past(rst) && !pinIoOe_n[0] |-> pinIoOut[0] == $past(periphOut.pwmA))
    else $error("pin0 not pwm a");
endmodule // port_e_pin_control_monitor
bind port_e_pin_control port_e_pin_control_monitor port_e_pin_control_monitor_i (
  .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .regRd(regRd), .regRdata(regRdata), .masterClearEnableCfg(masterClearEnableCfg),
  .unit3PinSelectCfg(unit3PinSelectCfg), .periphOut(periphOut), .pinIoOut(pinIoOut),
  .pinIoOe_n(pinIoOe_n), .pin3Input(pin3Input), .masterClear_n(masterClear_n));
`default_nettype wire

// [port_e_pin_partner.sv]
`timescale 1ns/10ps
`default_nettype none
module port_e_pin_partner (
  input  wire logic [2:0] pinIoOut,
  input  wire logic [2:0] pinIoOe_n,
  input  wire logic [2:0] extLevel,
  output logic      [2:0] pinIoIn
);
  // a driven pin shows its driver, a released one the outside level
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pinIoIn[i] = pinIoOe_n[i] ? extLevel[i] : pinIoOut[i];
    end
  end
endmodule // port_e_pin_partner
`default_nettype wire

// [port_e_pin_control_tb.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module port_e_pin_control_tb;
  logic                    clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
  logic                    masterClearEnableCfg = 1'b0, unit3PinSelectCfg = 1'b0;
  logic                    pin3Input = 1'b0, masterClear_n, pin3PullupEnable;
  logic [1:0]              regAddr = 2'h0;
  logic [7:0]              regWdata = 8'h00, regRdata;
  logic [2:0]              extLevel = 3'h0, pinIoIn, pinIoOut, pinIoOe_n;
  port_e_pkg::periph_out_s periphOut = 8'h00;
  port_e_pkg::periph_in_s  periphIn;
  int                      failures = 0, n_checks = 0;
  port_e_pin_control port_e_pin_control_i (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .masterClearEnableCfg(masterClearEnableCfg), .unit3PinSelectCfg(unit3PinSelectCfg),
    .periphOut(periphOut), .periphIn(periphIn), .pinIoIn(pinIoIn), .pinIoOut(pinIoOut),
    .pinIoOe_n(pinIoOe_n), .pin3Input(pin3Input), .masterClear_n(masterClear_n),
    .pin3PullupEnable(pin3PullupEnable));
  port_e_pin_partner port_e_pin_partner_i (.pinIoOut(pinIoOut), .pinIoOe_n(pinIoOe_n),
    .extLevel(extLevel), .pinIoIn(pinIoIn));
  always #2 clk = ~clk;
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 `CHK("rdata", e, regRdata)
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(2'h2, 8'h87);
    rd(2'h3, 8'h07);
    rd(2'h0, 8'h00);
    `CHK("oe", 3'h7, pinIoOe_n)
    wr(2'h1, 8'hf8);
    rd(2'h1, 8'h00);
    $display("test reset done");
    wr(2'h2, 8'h00);
    wr(2'h0, 8'h05);
    settle(2);
    `CHK("drive", 3'h5, pinIoOut)
    `CHK("oe", 3'h0, pinIoOe_n)
    rd(2'h1, 8'h05);
    periphOut <= 8'hea;
    settle(2);
    `CHK("prio", 3'h1, pinIoOut)
    unit3PinSelectCfg <= 1'b1;
    wr(2'h1, 8'h00);
    settle(2);
    `CHK("alt", 3'h0, pinIoOut)
    unit3PinSelectCfg <= 1'b0;
    periphOut <= 8'h6e;
    settle(2);
    `CHK("cmp3", 3'h1, pinIoOut)
    periphOut <= 8'h00;
    $display("test output done");
    wr(2'h2, 8'h07);
    wr(2'h3, 8'h00);
    extLevel <= 3'h6;
    pin3Input <= 1'b1;
    settle(8);
    rd(2'h0, 8'h0e);
    `CHK("cap5", 1'b1, periphIn.capture5)
    `CHK("cap3", 1'b0, periphIn.capture3)
    masterClearEnableCfg <= 1'b1;
    pin3Input <= 1'b0;
    settle(8);
    rd(2'h0, 8'h06);
    `CHK("clear", 1'b0, masterClear_n)
    `CHK("pullup", 1'b1, pin3PullupEnable)
    wr(2'h3, 8'h07);
    settle(8);
    rd(2'h0, 8'h00);
    `CHK("ana", 3'h7, periphIn.analogEn)
    $display("test input done");
    conclude();
  end
endmodule // port_e_pin_control_tb
`default_nettype wire
